// *** pkg/supervisor_map.svh ***
// constants, offsets and timing figures of the supervisor core
`ifndef SUPERVISOR_MAP_SVH
`define SUPERVISOR_MAP_SVH

// ------------------------------------------------------------
// clock and timebase rates
// ------------------------------------------------------------
`define CLK_HZ          25000000
`define TB_HZ           10240
`define MS_PER_S        1000

// ------------------------------------------------------------
// interval figures in milliseconds and external counts
// ------------------------------------------------------------
`define RST_MS          50
`define WD_SHORT_MS     100
`define WD_LONG_MS      1600
`define EXT_WD_CLKS     1024
`define EXT_LONG_CLKS   4096
`define EXT_RST_CLKS    512

// ------------------------------------------------------------
// register map (byte addresses) and fields
// ------------------------------------------------------------
`define ADDR_CTRL       8'h00
`define ADDR_STATUS     8'h04
`define ADDR_COUNT      8'h08
`define CTRL_WD_EN      0
`define CTRL_RESET      1'b1
`define CNT_W           16
`define DIV_W           16

`endif

// *** pkg/supervisor_pkg.sv ***
// types shared by the supervisor core
package supervisor_pkg;

  // which part of the cycle the supervisor is in
  typedef enum logic [0:0] {
    PH_WATCH = 1'b0,  // reset released, watchdog may run
    PH_RESET = 1'b1   // reset output held asserted
  } phase_e;

  // all sampled pins, one bit each
  typedef struct packed {
    logic low_line;      // supply below low-line threshold
    logic power_fail;    // power-fail input below reference
    logic backup;        // switched supply on backup source
    logic ce_in_n;       // incoming chip enable, active low
    logic tog;           // toggle input level
    logic tog_float;     // toggle input left floating
    logic src_sel;       // timebase select high
    logic src_float;     // timebase select floating
    logic tb_in;         // timebase pin level / clock
    logic tb_float;      // timebase pin floating
  } pins_s;

  // whole register state of the core
  typedef struct packed {
    pins_s           sync1;     // first synchroniser stage
    pins_s           sync2;     // second synchroniser stage
    logic            tb_prev;   // last external clock level
    logic [15:0]     div;       // internal timebase divider
    logic            tog_prev;  // toggle level at last tick
    phase_e          phase;     // reset or watching
    logic [15:0]     rst_cnt;   // ticks spent in reset
    logic [15:0]     wd_cnt;    // ticks since last service
    logic            long_to;   // post-reset timeout in use
    logic            fault_n;   // watchdog fault, active low
    logic            reset_n;   // reset output, active low
    logic            reset_hi;  // reset output, active high
    logic            ce_out_n;  // gated chip enable
    logic            pf_warn_n; // power-fail warning
    logic            batt_drv;  // backup active drive
    logic            wd_en;     // software watchdog enable
    logic            pready;    // apb ready
    logic            pslverr;   // apb error
    logic [31:0]     prdata;    // apb read data
  } state_s;

endpackage : supervisor_pkg

// *** design/supervisor_reset_watchdog.sv ***
// supervisor core: reset stretcher, watchdog, chip-enable and warning gates
//
// Local design decisions: the APB register port and the register offsets.
`include "supervisor_map.svh"

module supervisor_reset_watchdog
  import supervisor_pkg::*;
#(
  // clocks per internal timebase tick; shorten for simulation
  parameter int unsigned TB_DIV = `CLK_HZ / `TB_HZ
) (
  input  wire logic        clk,                 // 25 MHz core clock
  input  wire logic        rst,                 // async reset, high
  // comparator results and pins
  input  wire logic        low_line_sense,      // 1 = supply low
  input  wire logic        power_fail_sense,    // 1 = below ref
  input  wire logic        backup_sense,        // 1 = on backup
  input  wire logic        ce_in_n,             // chip enable in
  input  wire logic        service_toggle_in,   // toggle level
  input  wire logic        service_toggle_float,// toggle floating
  input  wire logic        timebase_source_select, // 1 = internal
  input  wire logic        timebase_select_float,  // select open
  input  wire logic        timebase_input,      // ext clock / level
  input  wire logic        timebase_input_float,// timebase pin open
  // outputs
  output logic             reset_n_out,         // reset, active low
  output logic             reset_out,           // reset, active high
  output logic             service_fault_out_n, // watchdog fault
  output logic             ce_out_n,            // gated chip enable
  output logic             power_fail_warn_out_n, // warning, low
  output logic             backup_active_drive, // high on backup
  // apb slave
  input  wire logic        psel,                // select
  input  wire logic        penable,             // access phase
  input  wire logic        pwrite,              // 1 = write
  input  wire logic [7:0]  paddr,               // byte address
  input  wire logic [31:0] pwdata,              // write data
  output logic [31:0]      prdata,              // read data
  output logic             pready,              // ready
  output logic             pslverr              // unmapped address
);

  // ------------------------------------------------------------
  // derived tick counts
  // ------------------------------------------------------------
  localparam logic [15:0] RST_TICKS =
    16'(`RST_MS * `TB_HZ / `MS_PER_S);
  localparam logic [15:0] WD_SHORT_TICKS =
    16'(`WD_SHORT_MS * `TB_HZ / `MS_PER_S);
  localparam logic [15:0] WD_LONG_TICKS =
    16'(`WD_LONG_MS * `TB_HZ / `MS_PER_S);
  localparam logic [15:0] EXT_WD   = 16'(`EXT_WD_CLKS);
  localparam logic [15:0] EXT_LONG = 16'(`EXT_LONG_CLKS);
  localparam logic [15:0] EXT_RST  = 16'(`EXT_RST_CLKS);
  localparam logic [15:0] DIV_LAST = 16'(TB_DIV - 1);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  state_s r;        // registered state
  state_s next_r;   // next state
  pins_s  raw;      // unsynchronised pins

  // helper terms, all combinational
  logic        ext_mode;     // external timebase selected
  logic        tick;         // one timebase step
  logic        service;      // toggle change seen
  logic        wd_active;    // watchdog allowed to count
  logic [15:0] wd_limit;     // current timeout in ticks
  logic [15:0] rst_limit;    // reset pulse in ticks
  logic        acc;          // apb access completes
  logic        setup;        // apb setup cycle

  // ------------------------------------------------------------
  // pin bundle
  // ------------------------------------------------------------
  // every input pin except clk, rst and the apb port is gathered so one
  // two-stage sync covers all of them
  always_comb begin
    raw.low_line   = low_line_sense;
    raw.power_fail = power_fail_sense;
    raw.backup     = backup_sense;
    raw.ce_in_n    = ce_in_n;
    raw.tog        = service_toggle_in;
    raw.tog_float  = service_toggle_float;
    raw.src_sel    = timebase_source_select;
    raw.src_float  = timebase_select_float;
    raw.tb_in      = timebase_input;
    raw.tb_float   = timebase_input_float;
  end

  // ------------------------------------------------------------
  // timing selection
  // ------------------------------------------------------------
  // select low and not floating means an external clock drives
  // the timebase pin; high or open means the internal divider
  always_comb begin
    ext_mode = !r.sync2.src_sel && !r.sync2.src_float;
    if (ext_mode) begin
      // counts of external clock edges
      rst_limit = EXT_RST;
      wd_limit  = r.long_to ? EXT_LONG : EXT_WD;
    end else begin
      rst_limit = RST_TICKS;
      if (r.long_to) begin
        // fixed long timeout after any reset
        wd_limit = WD_LONG_TICKS;
      end else if (!r.sync2.tb_in && !r.sync2.tb_float) begin
        // pin low: short period once serviced
        wd_limit = WD_SHORT_TICKS;
      end else begin
        // pin open (or high): default period
        wd_limit = WD_LONG_TICKS;
      end
    end
  end

  // ------------------------------------------------------------
  // tick, service and enable terms
  // ------------------------------------------------------------
  always_comb begin
    // external mode steps on rising edges of the synced clock;
    // this limits the external rate to well under clk / 2
    if (ext_mode) begin
      tick = r.sync2.tb_in && !r.tb_prev;
    end else begin
      tick = (r.div == DIV_LAST);
    end
    // a change between two tick samples is one service event
    service = tick && (r.sync2.tog != r.tog_prev)
              && !r.sync2.tog_float;
    // a floating toggle pin or software disable stops it
    wd_active = !r.sync2.tog_float && r.wd_en;
    // apb phases
    setup = psel && !penable;
    acc   = psel && penable && r.pready;
  end

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    next_r = r;

    // two flops before any logic reads a pin
    next_r.sync1   = raw;
    next_r.sync2   = r.sync1;
    next_r.tb_prev = r.sync2.tb_in;

    // internal divider runs freely; harmless in external mode
    next_r.div = (r.div == DIV_LAST) ? 16'h0000
               : r.div + 16'h0001;

    // toggle level follows on every tick, so edges that occur
    // during reset are consumed and never count afterwards
    if (tick) begin
      next_r.tog_prev = r.sync2.tog;
    end

    // --- supervisor sequence ---
    if (r.sync2.low_line) begin
      // low-line holds reset and restarts the stretch
      next_r.phase   = PH_RESET;
      next_r.rst_cnt = 16'h0000;
      next_r.long_to = 1'b1;
      next_r.fault_n = 1'b1;
    end else begin
      case (r.phase)
        PH_RESET: begin
          // toggles are not looked at here
          next_r.wd_cnt = 16'h0000;
          if (tick) begin
            if (r.rst_cnt + 16'h0001 >= rst_limit) begin
              // stretch complete: release, restart watchdog
              next_r.phase   = PH_WATCH;
              next_r.rst_cnt = 16'h0000;
              next_r.wd_cnt  = 16'h0000;
            end else begin
              next_r.rst_cnt = r.rst_cnt + 16'h0001;
            end
          end
        end
        PH_WATCH: begin
          if (!wd_active) begin
            // disabled: no count, no timeout
            next_r.wd_cnt = 16'h0000;
          end else if (service) begin
            // service clears count, fault and long period
            next_r.wd_cnt  = 16'h0000;
            next_r.long_to = 1'b0;
            next_r.fault_n = 1'b1;
          end else if (tick) begin
            if (r.wd_cnt + 16'h0001 >= wd_limit) begin
              // timeout: one reset pulse, fault latched low,
              // long period again so pulses repeat every 1.65s (50 ms pulse plus 1.6s) on the internal timebase, every 4608 edges in external mode
              next_r.phase   = PH_RESET;
              next_r.rst_cnt = 16'h0000;
              next_r.wd_cnt  = 16'h0000;
              next_r.fault_n = 1'b0;
              next_r.long_to = 1'b1;
            end else begin
              next_r.wd_cnt = r.wd_cnt + 16'h0001;
            end
          end
        end
        default: begin
          // unreachable code: fall back to reset
          next_r.phase = PH_RESET;
        end
      endcase
    end

    // --- outputs, all registered ---
    // reset low whenever the next phase is reset
    next_r.reset_n  = (next_r.phase != PH_RESET);
    next_r.reset_hi = (next_r.phase == PH_RESET);
    // chip enable blocked on low supply or backup
    if (r.sync2.low_line || r.sync2.backup) begin
      next_r.ce_out_n = 1'b1;
    end else begin
      next_r.ce_out_n = r.sync2.ce_in_n;
    end
    // comparator switched off in backup: warning forced low
    next_r.pf_warn_n = !(r.sync2.power_fail
                         || r.sync2.backup);
    next_r.batt_drv  = r.sync2.backup;

    // --- apb slave, zero wait states ---
    // ready rises in the first access cycle of each transfer
    next_r.pready = psel && !r.pready;
    if (setup) begin
      next_r.pslverr = 1'b0;
      next_r.prdata  = 32'h0000_0000;
      case (paddr)
        `ADDR_CTRL: begin
          next_r.prdata[`CTRL_WD_EN] = r.wd_en;
        end
        `ADDR_STATUS: begin
          // live view of the core
          next_r.prdata[4:0] = {r.sync2.low_line, wd_active,
                                r.long_to, !r.fault_n,
                                (r.phase == PH_RESET)};
        end
        `ADDR_COUNT: begin
          next_r.prdata[15:0] = r.wd_cnt;
        end
        default: begin
          // unmapped: error with zero data
          next_r.pslverr = 1'b1;
        end
      endcase
    end
    // a write lands only at the completing edge
    if (acc && pwrite && (paddr == `ADDR_CTRL)) begin
      next_r.wd_en = pwdata[`CTRL_WD_EN];
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // asserted reset means power-up: reset output held, long
  // timeout armed, fault released, chip enable blocked
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r           <= '0;
      r.phase     <= PH_RESET;
      r.long_to   <= 1'b1;
      r.fault_n   <= 1'b1;
      r.reset_n   <= 1'b0;
      r.reset_hi  <= 1'b1;
      r.ce_out_n  <= 1'b1;
      r.sync1.ce_in_n <= 1'b1;
      r.sync2.ce_in_n <= 1'b1;
      r.wd_en     <= `CTRL_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------
  // outputs straight from flops
  // ------------------------------------------------------------
  always_comb begin
    reset_n_out           = r.reset_n;
    reset_out             = r.reset_hi;
    service_fault_out_n   = r.fault_n;
    ce_out_n              = r.ce_out_n;
    power_fail_warn_out_n = r.pf_warn_n;
    backup_active_drive   = r.batt_drv;
    prdata                = r.prdata;
    pready                = r.pready;
    pslverr               = r.pslverr;
  end

endmodule : supervisor_reset_watchdog

// *** test/supervisor_props.sv ***
// checker for the supervisor core outputs
module supervisor_props #(
  parameter int unsigned TB_DIV = 4  // clocks per timebase tick
) (
  input wire logic        clk,                   // core clock
  input wire logic        rst,                   // async reset
  input wire logic        low_line_sense,        // supply low
  input wire logic        power_fail_sense,      // below reference
  input wire logic        backup_sense,          // on backup
  input wire logic        ce_in_n,               // chip enable in
  input wire logic        reset_n_out,           // reset, low
  input wire logic        reset_out,             // reset, high
  input wire logic        service_fault_out_n,   // fault, low
  input wire logic        ce_out_n,              // gated enable
  input wire logic        power_fail_warn_out_n, // warning, low
  input wire logic        psel,                  // apb select
  input wire logic        penable,               // apb access
  input wire logic [7:0]  paddr,                 // apb address
  input wire logic [31:0] prdata,                // apb read data
  input wire logic        pready,                // apb ready
  input wire logic        pslverr                // apb error
);
  // ----------------------------------------------------------
  // helper: length of the current reset low stretch
  // ----------------------------------------------------------
  localparam int RST_MIN = 511 * TB_DIV;  // one tick of slack
  logic [19:0] low_cnt;  // saturating low-cycle count

  // counts clocks while reset is low, cleared when released
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cnt <= '0;
    end else if (reset_n_out) begin
      low_cnt <= '0;
    end else if (low_cnt != '1) begin
      low_cnt <= low_cnt + 20'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------
  // assertions; inputs pass two flops plus the output flop
  // ----------------------------------------------------------
  a_reset_inverse: assert property (reset_out == !reset_n_out)
    else $error("reset outputs not inverse");
  a_lowline_reset: assert property (low_line_sense [*4] |-> !reset_n_out)
    else $error("low line did not hold reset");
  a_lowline_fault: assert property (low_line_sense [*4] |-> service_fault_out_n)
    else $error("low line did not clear fault");
  a_lowline_ce: assert property (low_line_sense [*4] |-> ce_out_n)
    else $error("low line did not block enable");
  a_backup_gates: assert property (backup_sense [*4] |-> ce_out_n && !power_fail_warn_out_n)
    else $error("backup did not force gates");
  a_warn_low: assert property (power_fail_sense [*4] |-> !power_fail_warn_out_n)
    else $error("warning not low");
  a_ce_pass: assert property ((!low_line_sense && !backup_sense && $stable(ce_in_n)) [*4] |-> ce_out_n == ce_in_n)
    else $error("enable not passed through");
  a_fault_pulse: assert property ($fell(service_fault_out_n) |-> !reset_n_out)
    else $error("fault fell without reset");
  a_pulse_long: assert property ($rose(reset_n_out) |-> low_cnt >= RST_MIN)
    else $error("reset stretch too short");
  a_apb_ready: assert property (psel && !penable |=> pready)
    else $error("apb answer late");
  a_apb_unmapped: assert property (pready && paddr > 8'h08 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");

  cover property ($rose(reset_n_out));
  cover property ($fell(service_fault_out_n));
  cover property (pready && pslverr);
endmodule : supervisor_props

bind supervisor_reset_watchdog supervisor_props #(.TB_DIV(TB_DIV)) u_props (
  .clk(clk), .rst(rst), .low_line_sense(low_line_sense),
  .power_fail_sense(power_fail_sense), .backup_sense(backup_sense),
  .ce_in_n(ce_in_n), .reset_n_out(reset_n_out), .reset_out(reset_out),
  .service_fault_out_n(service_fault_out_n), .ce_out_n(ce_out_n),
  .power_fail_warn_out_n(power_fail_warn_out_n), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr));

// *** test/host_model.sv ***
// host processor model driving the service toggle line
module host_model #(
  parameter int PER = 200  // clocks between toggles is PER + 1 (cnt runs 0 to PER)
) (
  input wire logic clk,      // core clock
  input wire logic rst,      // async reset
  input wire logic reset_n,  // reset from supervisor
  input wire logic run,      // software alive
  input wire logic kick,     // one stray toggle
  output logic     tog       // toggle line
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;  // clocks since last toggle

  // toggles while alive; holds the line while in reset unless kicked
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      tog <= 1'b0;
    end else if (kick) begin
      tog <= ~tog;  // stray toggle commanded by a scenario
    end else if (!run || !reset_n) begin
      cnt <= 0;
    end else if (cnt == PER) begin
      cnt <= 0;
      tog <= ~tog;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : host_model

// *** test/tb_supervisor_reset_watchdog.sv ***
// self-checking bench for the supervisor core
module tb_supervisor_reset_watchdog;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------
  // signals
  // ----------------------------------------------------------
  logic clk, rst, ll, pf, bk, ce_in_n, tfl, sel, sfl, tbi, tbfl;
  logic psel, penable, pwrite, run, kick, tog;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic rn, ro, flt, ceo, pfw, bad, pready, pslverr;
  int err_total, samples_checked, cyc;

  supervisor_reset_watchdog #(.TB_DIV(4)) dut (
    .clk(clk), .rst(rst), .low_line_sense(ll), .power_fail_sense(pf),
    .backup_sense(bk), .ce_in_n(ce_in_n), .service_toggle_in(tog),
    .service_toggle_float(tfl), .timebase_source_select(sel),
    .timebase_select_float(sfl), .timebase_input(tbi),
    .timebase_input_float(tbfl), .reset_n_out(rn), .reset_out(ro),
    .service_fault_out_n(flt), .ce_out_n(ceo),
    .power_fail_warn_out_n(pfw), .backup_active_drive(bad),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  host_model #(.PER(200)) host (.clk(clk), .rst(rst), .reset_n(rn),
    .run(run), .kick(kick), .tog(tog));

  // ----------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // whole run is near 33k clocks; 80000 is well over double that, a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      err_total++;
      test_done();
    end
  end

  // ----------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // apb master: setup, then access until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // no answer within the limit counts as a mismatch
    if (n >= 50) err_total++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // clocks until reset output reaches a level
  task automatic wait_rst(input logic lvl, input int lim,
                          output int n);
    n = 0;
    while (rn !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_rst

  // reset output must stay released for n clocks
  task automatic quiet(input int n);
    logic ok;
    ok = 1'b1;
    repeat (n) begin
      @(negedge clk);
      if (rn !== 1'b1) ok = 1'b0;
    end
    chk("no_reset", 1, ok);
  endtask : quiet

  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_power_on();
    int n;
    wait_rst(1'b1, 3000, n);
    chk("stretch", 1, n >= 2040 && n <= 2070);
    chk("reset_hi", 0, ro);
  endtask : t_power_on

  task automatic t_regs();
    logic [31:0] q;
    logic e;
    apb(1'b0, 8'h00, 32'h0, q, e);
    chk("ctrl_rst", 32'h1, q);
    apb(1'b0, 8'h04, 32'h0, q, e);
    chk("status", 32'h0, q & 32'h11);
    apb(1'b1, 8'h0c, 32'h0, q, e);
    chk("wr_err", 1, e);
    apb(1'b0, 8'h0c, 32'h0, q, e);
    chk("rd_err", 1, e);
    apb(1'b1, 8'h00, 32'h0, q, e);
    apb(1'b0, 8'h00, 32'h0, q, e);
    chk("ctrl_off", 32'h0, q);
    apb(1'b1, 8'h00, 32'h1, q, e);
  endtask : t_regs

  task automatic t_gates();
    ce_in_n <= 1'b0;
    pf <= 1'b1;
    repeat (6) @(negedge clk);
    chk("ce_pass", 0, ceo);
    chk("warn", 0, pfw);
    @(posedge clk);
    pf <= 1'b0;
    bk <= 1'b1;
    repeat (6) @(negedge clk);
    chk("ce_backup", 1, ceo);
    chk("warn_bk", 0, pfw);
    chk("drive", 1, bad);
    @(posedge clk);
    bk <= 1'b0;
    repeat (6) @(negedge clk);
    chk("warn_off", 1, pfw);
  endtask : t_gates

  // long timeout, short timeout, pulse, stray toggle, low line
  task automatic t_watchdog();
    int n;
    quiet(4400);
    @(posedge clk);
    run <= 1'b1;
    quiet(6000);
    @(posedge clk);
    run <= 1'b0;
    wait_rst(1'b0, 4400, n);
    chk("short_to", 1, n >= 3880 && n <= 4120);
    chk("fault", 0, flt);
    repeat (200) @(posedge clk);
    kick <= 1'b1;
    @(posedge clk);
    kick <= 1'b0;
    wait_rst(1'b1, 3000, n);
    repeat (40) @(negedge clk);
    chk("fault_hold", 0, flt);
    @(posedge clk);
    ll <= 1'b1;
    repeat (6) @(negedge clk);
    chk("ll_reset", 0, rn);
    chk("ll_fault", 1, flt);
    chk("ll_ce", 1, ceo);
    @(posedge clk);
    ll <= 1'b0;
    wait_rst(1'b1, 3000, n);
    chk("ll_stretch", 1, n >= 2040 && n <= 2070);
  endtask : t_watchdog

  // floating toggle pin stops the watchdog
  task automatic t_float();
    int n;
    run <= 1'b1;
    repeat (1000) @(posedge clk);
    tfl <= 1'b1;
    run <= 1'b0;
    quiet(4500);
    @(posedge clk);
    tfl <= 1'b0;
    wait_rst(1'b0, 4400, n);
    chk("float_end", 1, n < 4400);
    wait_rst(1'b1, 3000, n);
    @(posedge clk);
    run <= 1'b1;
    repeat (300) @(negedge clk);
    chk("serviced", 1, flt);
  endtask : t_float

  initial begin
    {ll, pf, bk, tfl, sfl, tbi, tbfl} = '0;
    {psel, penable, pwrite, run, kick} = '0;
    ce_in_n = 1'b1;
    sel = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_power_on();
    t_regs();
    t_gates();
    t_watchdog();
    t_float();
    test_done();
  end
endmodule : tb_supervisor_reset_watchdog
